// File: hdl/clgs_pkg.sv
// Shared constants, register map and carrier types of the gate input select block
package clgs_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int unsigned ADDR_W     = 4;
	localparam int unsigned DATA_W     = 16;
	localparam int unsigned N_GATE     = 4;
	localparam int unsigned N_SRC      = 4;
	localparam int unsigned N_CAND     = 8;
	localparam int unsigned SEL_W      = 3;
	localparam int unsigned GATE_EN_W  = 2 * N_SRC;

	// ****************************************************************
	// Register indices on the plain register port
	// ****************************************************************
	localparam logic [ADDR_W-1:0] IDX_SEL_LOW  = 4'h0;
	localparam logic [ADDR_W-1:0] IDX_SEL_HIGH = 4'h1;
	localparam logic [ADDR_W-1:0] IDX_POL      = 4'h2;
	localparam logic [ADDR_W-1:0] IDX_SRC_SEL  = 4'h3;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [DATA_W-1:0] RST_SEL_LOW  = 16'h0000;
	localparam logic [DATA_W-1:0] RST_SEL_HIGH = 16'h0000;
	localparam logic [DATA_W-1:0] RST_POL      = 16'h0000;
	localparam logic [DATA_W-1:0] RST_SRC_SEL  = 16'h0000;
	localparam logic [DATA_W-1:0] RD_UNMAPPED  = 16'h0000;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	// Enable byte of a gate: bit 2k+1 true form, bit 2k inverted form
	localparam int unsigned GATE1_LSB    = 0;   // In low select register
	localparam int unsigned GATE2_LSB    = 8;   // In low select register
	localparam int unsigned GATE3_LSB    = 0;   // In high select register
	localparam int unsigned GATE4_LSB    = 8;   // In high select register
	localparam int unsigned EN_TRUE_OFS  = 1;
	localparam int unsigned EN_INV_OFS   = 0;
	localparam int unsigned POL_LSB      = 0;
	localparam int unsigned SRC_FIELD_STRIDE = 4;
	// Writable bits; the rest read as zero
	localparam logic [DATA_W-1:0] POL_MASK     = 16'h000f;
	localparam logic [DATA_W-1:0] SRC_SEL_MASK = 16'h7777;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} clgs_bus_req_s;

	// Eight candidate signals for each of the four source multiplexers
	typedef struct packed {
		logic [N_CAND-1:0] mux4;
		logic [N_CAND-1:0] mux3;
		logic [N_CAND-1:0] mux2;
		logic [N_CAND-1:0] mux1;
	} clgs_src_cand_s;

endpackage : clgs_pkg

// File: hdl/clgs_gate.sv
// One gate channel: OR of enabled true and inverted sources, then polarity
`timescale 1ns/10ps
`default_nettype none

module clgs_gate #(
	parameter int unsigned N_SRC = 4
) (
	// Sources and selection
	input  wire logic [N_SRC-1:0]   src_in,
	input  wire logic [2*N_SRC-1:0] enable_in,
	input  wire logic               invert_in,
	// Result
	output logic                    gate_out
);

	logic gate_raw;

	always_comb begin
		gate_raw = 1'b0;                                         // RULE_09
		for (int k = 0; k < N_SRC; k++) begin
			if (enable_in[2*k+1]) begin
				gate_raw = gate_raw | src_in[k];                     // RULE_02
			end
			if (enable_in[2*k]) begin
				gate_raw = gate_raw | ~src_in[k];                    // RULE_03
			end
		end
		gate_out = invert_in ? ~gate_raw : gate_raw;             // RULE_07
	end

endmodule : clgs_gate

`default_nettype wire

// File: hdl/clgs_top.sv
// Gate input selection of a configurable logic cell with its register file
// Summary of operation
// RULE_01 - Gate 1 enables sit in low select bits 7..0, source 4 true at top.
// RULE_02 - A set true enable passes its source unchanged into that gate.
// RULE_03 - A set inverted enable passes the complemented source into that gate.
// RULE_04 - Gate 4 enables sit in high select bits 15..8, paired true then inverted.
// RULE_05 - Gate 3 enables sit in high select bits 7..0, paired true then inverted.
// RULE_06 - Gate 2 source 1 inverted enable is bit 8 of the low select register.
// RULE_07 - A gate's polarity bit at 1 inverts that gate's combined output.
// RULE_08 - Each data source comes from its own 3-bit mux select field.
// RULE_09 - A gate ORs its enabled inputs; no enabled input gives low.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module clgs_top
	import clgs_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	// Register port
	input  wire clgs_pkg::clgs_bus_req_s  bus_req_in,
	output logic [clgs_pkg::DATA_W-1:0]   rd_data_out,
	// Data source candidates
	input  wire clgs_pkg::clgs_src_cand_s src_cand_in,
	// Toward the logic cell
	output logic [clgs_pkg::N_SRC-1:0]    data_src_out,
	output logic [clgs_pkg::N_GATE-1:0]   gate_out
);

	import clgs_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [DATA_W-1:0] sel_low;
		logic [DATA_W-1:0] sel_high;
		logic [DATA_W-1:0] pol;
		logic [DATA_W-1:0] src_sel;
		logic [DATA_W-1:0] rd_data;
		logic [N_SRC-1:0]  data_src;
		logic [N_GATE-1:0] gate;
	} clgs_state_s;

	localparam clgs_state_s STATE_RST = '{
		sel_low:  RST_SEL_LOW,
		sel_high: RST_SEL_HIGH,
		pol:      RST_POL,
		src_sel:  RST_SRC_SEL,
		rd_data:  RD_UNMAPPED,
		data_src: '0,
		gate:     '0
	};

	clgs_state_s state_ff;
	clgs_state_s nxt_state;

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Register read view; unmapped indices answer zero
	function automatic logic [DATA_W-1:0] read_reg(
		input clgs_state_s       st,
		input logic [ADDR_W-1:0] idx
	);
		logic [DATA_W-1:0] val;
		val = RD_UNMAPPED;
		case (idx)
			IDX_SEL_LOW:  val = st.sel_low;
			IDX_SEL_HIGH: val = st.sel_high;
			IDX_POL:      val = st.pol & POL_MASK;
			IDX_SRC_SEL:  val = st.src_sel & SRC_SEL_MASK;
			default:      val = RD_UNMAPPED;
		endcase
		return val;
	endfunction : read_reg

	// Write hit on a given index
	function automatic logic write_hit(
		input clgs_bus_req_s     req,
		input logic [ADDR_W-1:0] idx
	);
		return req.wr && (req.addr == idx);
	endfunction : write_hit

	// One source multiplexer: pick candidate by its 3-bit field
	function automatic logic pick_src(
		input logic [N_CAND-1:0] cand,
		input logic [SEL_W-1:0]  sel
	);
		return cand[sel];
	endfunction : pick_src

	// ****************************************************************
	// Source multiplexers
	// ****************************************************************
	logic [SEL_W-1:0] mux_sel [N_SRC];
	logic [N_SRC-1:0] data_src;

	always_comb begin
		for (int m = 0; m < N_SRC; m++) begin
			mux_sel[m] = state_ff.src_sel[m*SRC_FIELD_STRIDE +: SEL_W];    // RULE_08
		end
	end

	// Candidates are combinational so a source change reaches the gate
	// register one edge later, matching the gate path latency
	always_comb begin
		data_src[0] = pick_src(src_cand_in.mux1, mux_sel[0]);             // RULE_08
		data_src[1] = pick_src(src_cand_in.mux2, mux_sel[1]);
		data_src[2] = pick_src(src_cand_in.mux3, mux_sel[2]);
		data_src[3] = pick_src(src_cand_in.mux4, mux_sel[3]);
	end

	// ****************************************************************
	// Enable slices per gate
	// ****************************************************************
	logic [GATE_EN_W-1:0] gate_en [N_GATE];

	always_comb begin
		gate_en[0] = state_ff.sel_low[GATE1_LSB +: GATE_EN_W];            // RULE_01
		gate_en[1] = state_ff.sel_low[GATE2_LSB +: GATE_EN_W];            // RULE_06
		gate_en[2] = state_ff.sel_high[GATE3_LSB +: GATE_EN_W];           // RULE_05
		gate_en[3] = state_ff.sel_high[GATE4_LSB +: GATE_EN_W];           // RULE_04
	end

	// ****************************************************************
	// Gate channels
	// ****************************************************************
	logic [N_GATE-1:0] gate_val;

	for (genvar g = 0; g < N_GATE; g++) begin : g_gate
		clgs_gate #(
			.N_SRC     (N_SRC)
		) u_gate (
			.src_in    (data_src),
			.enable_in (gate_en[g]),
			.invert_in (state_ff.pol[POL_LSB + g]),                      // RULE_07
			.gate_out  (gate_val[g])
		);
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		nxt_state = state_ff;

		// Register writes; a write takes effect at the next edge
		if (write_hit(bus_req_in, IDX_SEL_LOW)) begin
			nxt_state.sel_low = bus_req_in.wdata;                         // RULE_01
		end
		if (write_hit(bus_req_in, IDX_SEL_HIGH)) begin
			nxt_state.sel_high = bus_req_in.wdata;                        // RULE_04
		end
		if (write_hit(bus_req_in, IDX_POL)) begin
			nxt_state.pol = bus_req_in.wdata & POL_MASK;                  // RULE_07
		end
		if (write_hit(bus_req_in, IDX_SRC_SEL)) begin
			nxt_state.src_sel = bus_req_in.wdata & SRC_SEL_MASK;          // RULE_08
		end

		// Read data stands only in the cycle after the strobe
		if (bus_req_in.rd) begin
			nxt_state.rd_data = read_reg(state_ff, bus_req_in.addr);
		end else begin
			nxt_state.rd_data = RD_UNMAPPED;
		end

		// Registered outputs keep every output glitch free
		nxt_state.data_src = data_src;
		nxt_state.gate     = gate_val;                                   // RULE_09
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_ff <= STATE_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign rd_data_out  = state_ff.rd_data;
	assign data_src_out = state_ff.data_src;
	assign gate_out     = state_ff.gate;

endmodule : clgs_top

`default_nettype wire

// File: verification/clgs_props.sv
// Port-level checker of the gate input select block
`timescale 1ns/10ps
`default_nettype none
module clgs_props
	import clgs_pkg::*;
(
	// Clock and reset
	input wire logic                        clk_in,
	input wire logic                        rst_n_in,
	// Watched ports
	input wire clgs_pkg::clgs_bus_req_s     bus_req_in,
	input wire logic [clgs_pkg::DATA_W-1:0] rd_data_out,
	input wire clgs_pkg::clgs_src_cand_s    src_cand_in,
	input wire logic [clgs_pkg::N_SRC-1:0]  data_src_out,
	input wire logic [clgs_pkg::N_GATE-1:0] gate_out
);
	// ****************************************
	// Shadow of the registers
	// ****************************************
	logic [15:0] lo_ff, hi_ff, pol_ff, sel_ff;
	logic [3:0]  src, exp_gate;
	logic [7:0]  both;
	// Enable bytes of all four gates, gate 1 lowest
	logic [31:0] all_en;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			{lo_ff, hi_ff, pol_ff, sel_ff} <= 64'h0;
		end else if (bus_req_in.wr) begin
			case (bus_req_in.addr)
				IDX_SEL_LOW: lo_ff <= bus_req_in.wdata;
				IDX_SEL_HIGH: hi_ff <= bus_req_in.wdata;
				IDX_POL: pol_ff <= bus_req_in.wdata & POL_MASK;
				IDX_SRC_SEL: sel_ff <= bus_req_in.wdata & SRC_SEL_MASK;
				default: ;
			endcase
		end
	end
	always_comb begin
		src = {src_cand_in.mux4[sel_ff[14:12]], src_cand_in.mux3[sel_ff[10:8]],
			src_cand_in.mux2[sel_ff[6:4]], src_cand_in.mux1[sel_ff[2:0]]};
		both = {src[3], ~src[3], src[2], ~src[2], src[1], ~src[1], src[0], ~src[0]};
		all_en = {hi_ff, lo_ff};
		for (int g = 0; g < 4; g++) begin
			exp_gate[g] = (|(all_en[8*g +: 8] & both)) ^ pol_ff[g];
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_read_low_sel: assert property (bus_req_in.rd && bus_req_in.addr == IDX_SEL_LOW
		|=> rd_data_out == lo_ff) else $error("low select readback wrong");
	a_read_high_sel: assert property (bus_req_in.rd && bus_req_in.addr == IDX_SEL_HIGH
		|=> rd_data_out == hi_ff) else $error("high select readback wrong");
	a_read_polarity: assert property (bus_req_in.rd && bus_req_in.addr == IDX_POL
		|=> rd_data_out == pol_ff) else $error("polarity readback wrong");
	a_read_src_sel: assert property (bus_req_in.rd && bus_req_in.addr == IDX_SRC_SEL
		|=> rd_data_out == sel_ff) else $error("source select readback wrong");
	a_read_idle_zero: assert property (!(bus_req_in.rd && bus_req_in.addr < 4)
		|=> rd_data_out == 16'h0000) else $error("read data not zero");
	a_source_mux: assert property ($past(rst_n_in) |-> data_src_out == $past(src))
		else $error("data source selection wrong");
	a_gate_value: assert property ($past(rst_n_in) |-> gate_out == $past(exp_gate))
		else $error("gate output wrong");
	a_pol_only_gate: assert property (lo_ff == 16'h0 && hi_ff == 16'h0
		|=> gate_out == $past(pol_ff[3:0])) else $error("unused gate not polarity only");
	c_gate_high: cover property (gate_out != 4'h0 && pol_ff == 16'h0);
	c_read_back: cover property (bus_req_in.rd ##1 rd_data_out != 16'h0);
	c_pol_set: cover property (pol_ff != 16'h0 && gate_out == 4'hf);
endmodule : clgs_props
`default_nettype wire

// File: verification/clgs_top_bench.sv
// Self-checking bench of the gate input select block
`timescale 1ns/10ps
`default_nettype none
module clgs_top_bench;
	import clgs_pkg::*;
	logic           clk_in, rst_n_in;
	clgs_bus_req_s  bus_req_in;
	clgs_src_cand_s src_cand_in;
	logic [15:0]    rd_data_out;
	logic [3:0]     data_src_out, gate_out, s, eg;
	int             err_total, checks;
	// Written value and expected readback; unused bits read zero
	logic [15:0]    wv[4] = '{16'ha5c3, 16'h3c96, 16'hffff, 16'hffff};
	logic [15:0]    rv[4] = '{16'ha5c3, 16'h3c96, 16'h000f, 16'h7777};
	clgs_top clgs_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req_in),
		.rd_data_out(rd_data_out), .src_cand_in(src_cand_in), .data_src_out(data_src_out),
		.gate_out(gate_out));
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// ****************************************
	// Access and compare tasks
	// ****************************************
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		bus_req_in <= {a, d, 2'b10};
		@(posedge clk_in);
		bus_req_in <= '0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_in);
		bus_req_in <= {a, 16'h0000, 2'b01};
		@(posedge clk_in);
		bus_req_in <= '0;
		#1 cmp(rd_data_out, exp);
	endtask : rd
	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask : tick
	task automatic complete_run;
		if (err_total == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	initial begin
		// Generous bound; the sequence needs about 320 cycles
		#125000;
		err_total++;
		complete_run();
	end
	initial begin
		bus_req_in = '0;
		src_cand_in = '0;
		err_total = 0;
		checks = 0;
		// Second pass checks that a mid-run reset clears the four registers and the gate outputs again
		for (int p = 0; p < 2; p++) begin
			rst_n_in <= 1'b0;
			repeat (3) @(posedge clk_in);
			rst_n_in <= 1'b1;
			for (int a = 0; a < 4; a++) rd(4'(a), 16'h0000);
			// Cleared enables and polarity leave every gate low
			cmp({12'h000, gate_out}, 16'h0000);
			if (p == 0) begin
				wr(4'h9, 16'hffff);
				rd(4'h9, 16'h0000);
				for (int a = 0; a < 4; a++) begin
					wr(4'(a), wv[a]);
					rd(4'(a), rv[a]);
				end
				wr(IDX_POL, 16'h0000);
				// Each mux picks a different candidate so swapped fields show
				for (int v = 0; v < 8; v++) begin
					wr(IDX_SRC_SEL, {1'b0, 3'(v+3), 1'b0, 3'(v+2), 1'b0, 3'(v+1), 1'b0, 3'(v)});
					src_cand_in <= {8'h01 << 3'(v+3), 8'h01 << 3'(v+2), 8'h01 << 3'(v+1), 8'h01 << 3'(v)};
					tick();
					cmp({12'h000, data_src_out}, 16'h000f);
					src_cand_in <= ~src_cand_in;
					tick();
					cmp({12'h000, data_src_out}, 16'h0000);
				end
				// One enable bit at a time, both source levels
				for (int b = 0; b < 32; b++) begin
					wr(IDX_SEL_LOW, 16'(32'h1 << b));
					wr(IDX_SEL_HIGH, 16'((32'h1 << b) >> 16));
					for (int q = 0; q < 2; q++) begin
						s = q ? 4'h5 : 4'ha;
						src_cand_in <= {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
						eg = 4'h0;
						eg[b / 8] = s[(b % 8) / 2] ^ ~b[0];
						tick();
						cmp({12'h000, gate_out}, {12'h000, eg});
					end
				end
				wr(IDX_SEL_HIGH, 16'h0000);
				wr(IDX_SEL_LOW, 16'h00aa);
				src_cand_in <= {8'hff, 24'h000000};
				for (int v = 0; v < 16; v++) begin
					wr(IDX_POL, 16'(v));
					tick();
					cmp({12'h000, gate_out}, {12'h000, 4'(v) ^ 4'h1});
				end
			end
		end
		complete_run();
	end
endmodule : clgs_top_bench
bind clgs_top clgs_props clgs_props_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.bus_req_in(bus_req_in), .rd_data_out(rd_data_out), .src_cand_in(src_cand_in),
	.data_src_out(data_src_out), .gate_out(gate_out));
`default_nettype wire
